// ### mol_limiter.sv
`timescale 1ns/1ns
// Notes on behaviour
// - Active only when closed loop bit set
// - Ceiling register holds max current in mA
// - Rated setting is continuous current in mA
// - Peak setting in tenths of percent
// - Peak duration setting in milliseconds
// - Threshold compared to accumulator selects limit
// - Applied limit readable by software
// - Status reads 0 inactive, 1 active
// - Needs peak above rated and nonzero duration
// - Limit derived from rated, peak, duration
// - Peak allowed until limit, then rated
// - Effective peak never above ceiling
module mol_limiter #(
  parameter int TICK_CYCLES_P = mol_pkg::TICK_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] motorCurrent,
  output logic      [15:0] appliedCurrentLimit,
  output logic             limiterActive
);
  import mol_pkg::*;

  // Register select produced by the address decoder
  typedef enum logic [3:0] {
    SEL_CTRL,
    SEL_MAXCUR,
    SEL_RATED,
    SEL_PEAKPCT,
    SEL_PEAKDUR,
    SEL_THRESH,
    SEL_ACCUM,
    SEL_LIMIT,
    SEL_STATUS,
    SEL_CURRENT,
    SEL_NONE
  } mol_regsel_type;

  // Software configuration
  logic [31:0]    ctrl_reg;
  logic [31:0]    ctrl_next;
  logic [15:0]    maxCur_reg;
  logic [15:0]    maxCur_next;
  logic [15:0]    rated_reg;
  logic [15:0]    rated_next;
  logic [15:0]    peakPct_reg;
  logic [15:0]    peakPct_next;
  logic [15:0]    peakDur_reg;
  logic [15:0]    peakDur_next;
  // Limiter state
  logic [63:0]    accum_reg;
  logic [63:0]    accum_next;
  logic [15:0]    limit_reg;
  logic [15:0]    limit_next;
  mol_state_type  state_reg;
  mol_state_type  state_next;
  // Tick counter and read data
  logic [31:0]    tick_reg;
  logic [31:0]    tick_next;
  logic [31:0]    prdata_reg;
  logic [31:0]    prdata_next;

  // Derived values
  logic           closedLoop;
  logic [15:0]    peakEff;
  logic           enabled;
  logic [63:0]    threshold;
  logic [63:0]    ratedSq;
  logic [63:0]    curSq;
  logic           tick;
  logic           access;
  logic           readSetup;
  mol_regsel_type regSel;

  // Saturate a 64-bit quantity to one bus word; software sees all ones on overflow
  function automatic logic [31:0] sat32(input logic [63:0] v);
    if (v[63:32] != 32'h0) begin
      return 32'hffffffff;
    end
    return v[31:0];
  endfunction

  // Square of a 16-bit current; 64 bits keep the product exact
  function automatic logic [63:0] square(input logic [15:0] v);
    return 64'(v) * 64'(v);
  endfunction

  // Peak current from rated and tenths of a percent, clipped at the ceiling
  function automatic logic [15:0] peak_limit(input logic [15:0] ratedMa,
                                             input logic [15:0] permille,
                                             input logic [15:0] ceilingMa);
    logic [31:0] raw;
    raw = 32'(({16'h0, ratedMa} * {16'h0, permille}) / PERMILLE);
    if (raw > {16'h0, ceilingMa}) begin
      return ceilingMa;
    end
    return raw[15:0];
  endfunction

  // Byte address to register select; unmapped or unaligned addresses give none
  function automatic mol_regsel_type decode_addr(input logic [11:0] addr);
    mol_regsel_type sel;
    if (addr == ADDR_CTRL) begin
      sel = SEL_CTRL;
    end else if (addr == ADDR_MAXCUR) begin
      sel = SEL_MAXCUR;
    end else if (addr == ADDR_RATED) begin
      sel = SEL_RATED;
    end else if (addr == ADDR_PEAKPCT) begin
      sel = SEL_PEAKPCT;
    end else if (addr == ADDR_PEAKDUR) begin
      sel = SEL_PEAKDUR;
    end else if (addr == ADDR_THRESH) begin
      sel = SEL_THRESH;
    end else if (addr == ADDR_ACCUM) begin
      sel = SEL_ACCUM;
    end else if (addr == ADDR_LIMIT) begin
      sel = SEL_LIMIT;
    end else if (addr == ADDR_STATUS) begin
      sel = SEL_STATUS;
    end else if (addr == ADDR_CURRENT) begin
      sel = SEL_CURRENT;
    end else begin
      sel = SEL_NONE;
    end
    return sel;
  endfunction

  // Configuration decoding and derived thermal limit
  always_comb begin
    closedLoop = ctrl_reg[CLOSED_LOOP_BIT];
    peakEff    = peak_limit(rated_reg, peakPct_reg, maxCur_reg);
    enabled    = closedLoop && (peakEff > rated_reg) && (peakDur_reg != 16'h0);
    ratedSq    = square(rated_reg);
    // Excess energy over the peak duration, in mA^2*ms; zero when peak is not above rated
    threshold  = 64'h0;
    if (peakEff > rated_reg) begin
      threshold = (square(peakEff) - ratedSq) * 64'(peakDur_reg);
    end
    curSq      = square(motorCurrent);
    tick       = (tick_reg == 32'(TICK_CYCLES_P - 1));
    access     = psel && penable;
    readSetup  = psel && !penable && !pwrite;
    regSel     = decode_addr(paddr);
  end

  // Millisecond tick; free running, so a step may be short right after enabling
  always_comb begin
    tick_next = tick ? 32'h0 : tick_reg + 32'h1;
  end

  // Accumulator, limit selection and state
  always_comb begin
    accum_next = accum_reg;
    state_next = state_reg;
    limit_next = limit_reg;
    if (!enabled) begin
      accum_next = 64'h0;
      state_next = ST_OFF;
      limit_next = peakEff;
    end else begin
      if (tick) begin
        if (curSq > ratedSq) begin
          accum_next = accum_reg + (curSq - ratedSq);
        end else begin
          // Decay by one sixteenth per tick; a step that takes the accumulator below threshold switches the limit back to peak
          accum_next = accum_reg - (accum_reg >> DECAY_SHIFT);
        end
      end
      case (state_reg)
        ST_OFF: begin
          state_next = ST_PEAK;
          limit_next = peakEff;
        end
        ST_PEAK: begin
          limit_next = peakEff;
          if (accum_next >= threshold) begin
            state_next = ST_RATED;
            limit_next = rated_reg;
          end
        end
        default: begin
          limit_next = rated_reg;
          if (accum_next < threshold) begin
            state_next = ST_PEAK;
            limit_next = peakEff;
          end
        end
      endcase
    end
  end

  // APB writes; only bits 15:0 of a value word are kept
  always_comb begin
    ctrl_next    = ctrl_reg;
    maxCur_next  = maxCur_reg;
    rated_next   = rated_reg;
    peakPct_next = peakPct_reg;
    peakDur_next = peakDur_reg;
    if (access && pwrite) begin
      if (regSel == SEL_CTRL) begin
        ctrl_next = {31'h0, pwdata[CLOSED_LOOP_BIT]};
      end else if (regSel == SEL_MAXCUR) begin
        maxCur_next = pwdata[15:0];
      end else if (regSel == SEL_RATED) begin
        rated_next = pwdata[15:0];
      end else if (regSel == SEL_PEAKPCT) begin
        peakPct_next = pwdata[15:0];
      end else if (regSel == SEL_PEAKDUR) begin
        peakDur_next = pwdata[15:0];
      end
    end
  end

  // Read data is captured in the setup cycle, so the access phase needs no wait state
  always_comb begin
    prdata_next = prdata_reg;
    if (readSetup) begin
      if (regSel == SEL_CTRL) begin
        prdata_next = ctrl_reg;
      end else if (regSel == SEL_MAXCUR) begin
        prdata_next = {16'h0, maxCur_reg};
      end else if (regSel == SEL_RATED) begin
        prdata_next = {16'h0, rated_reg};
      end else if (regSel == SEL_PEAKPCT) begin
        prdata_next = {16'h0, peakPct_reg};
      end else if (regSel == SEL_PEAKDUR) begin
        prdata_next = {16'h0, peakDur_reg};
      end else if (regSel == SEL_THRESH) begin
        prdata_next = sat32(threshold);
      end else if (regSel == SEL_ACCUM) begin
        prdata_next = sat32(accum_reg);
      end else if (regSel == SEL_LIMIT) begin
        prdata_next = {16'h0, limit_reg};
      end else if (regSel == SEL_STATUS) begin
        prdata_next = {31'h0, (state_reg != ST_OFF)};
      end else if (regSel == SEL_CURRENT) begin
        prdata_next = {16'h0, motorCurrent};
      end else begin
        prdata_next = 32'h0;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_reg    <= 32'h0;
      maxCur_reg  <= MAXCUR_RST;
      rated_reg   <= RATED_RST;
      peakPct_reg <= PEAKPCT_RST;
      peakDur_reg <= PEAKDUR_RST;
    end else begin
      ctrl_reg    <= ctrl_next;
      maxCur_reg  <= maxCur_next;
      rated_reg   <= rated_next;
      peakPct_reg <= peakPct_next;
      peakDur_reg <= peakDur_next;
    end
  end

  // Tick counter
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tick_reg <= 32'h0;
    end else begin
      tick_reg <= tick_next;
    end
  end

  // Limiter state; the reset configuration permits a peak of zero, hence a zero limit
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      accum_reg <= 64'h0;
      limit_reg <= 16'h0;
      state_reg <= ST_OFF;
    end else begin
      accum_reg <= accum_next;
      limit_reg <= limit_next;
      state_reg <= state_next;
    end
  end

  // Read data register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata_reg <= 32'h0;
    end else begin
      prdata_reg <= prdata_next;
    end
  end

  // No wait states: read data already stands in its flop in the access phase
  assign pready              = 1'b1;
  assign pslverr             = 1'b0;
  assign prdata              = prdata_reg;
  assign appliedCurrentLimit = limit_reg;
  assign limiterActive       = (state_reg != ST_OFF);
endmodule

// ### mol_pkg.sv
package mol_pkg;
  // Register byte addresses
  localparam logic [11:0] ADDR_CTRL      = 12'h000;
  localparam logic [11:0] ADDR_MAXCUR    = 12'h004;
  localparam logic [11:0] ADDR_RATED     = 12'h008;
  localparam logic [11:0] ADDR_PEAKPCT   = 12'h00c;
  localparam logic [11:0] ADDR_PEAKDUR   = 12'h010;
  localparam logic [11:0] ADDR_THRESH    = 12'h014;
  localparam logic [11:0] ADDR_ACCUM     = 12'h018;
  localparam logic [11:0] ADDR_LIMIT     = 12'h01c;
  localparam logic [11:0] ADDR_STATUS    = 12'h020;
  localparam logic [11:0] ADDR_CURRENT   = 12'h024;
  // Field positions and reset values
  localparam int          CLOSED_LOOP_BIT = 0;
  localparam logic [15:0] MAXCUR_RST     = 16'h0000;
  localparam logic [15:0] RATED_RST      = 16'h0000;
  localparam logic [15:0] PEAKPCT_RST    = 16'h03e8;
  localparam logic [15:0] PEAKDUR_RST    = 16'h0000;
  // Timing: one accumulation step per millisecond
  localparam int CLK_HZ        = 50000000;
  localparam int TICK_MS       = 1;
  localparam int TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
  localparam int PERMILLE      = 1000;
  localparam int DECAY_SHIFT   = 4;
  typedef enum logic [1:0] {ST_OFF, ST_PEAK, ST_RATED} mol_state_type;
endpackage

// ### mol_limiter_properties.sv
`timescale 1ns/1ns
module mol_limiter_properties
  import mol_pkg::*;
#(parameter int TICK_CYCLES_P = 1) (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [15:0] motorCurrent,
  input wire logic [15:0] appliedCurrentLimit,
  input wire logic        limiterActive
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Read setup cycle latches the addressed value
  logic rdSet;
  assign rdSet = psel && !penable && !pwrite;
  a_ready_high: assert property (pready) else $error("pready low");
  a_no_slverr: assert property (!pslverr) else $error("pslverr high");
  a_reset_state: assert property (disable iff (1'b0) !rst_n |=> !limiterActive && appliedCurrentLimit == 16'h0)
    else $error("reset state");
  a_reset_read: assert property (disable iff (1'b0) !rst_n |=> prdata == 32'h0) else $error("reset read");
  a_status_read: assert property (rdSet && paddr == ADDR_STATUS |=> prdata == {31'h0, $past(limiterActive)})
    else $error("status read");
  a_limit_read: assert property (rdSet && paddr == ADDR_LIMIT |=> prdata == {16'h0, $past(appliedCurrentLimit)})
    else $error("limit read");
  a_current_read: assert property (rdSet && paddr == ADDR_CURRENT |=> prdata == {16'h0, $past(motorCurrent)})
    else $error("current read");
  a_unmapped_zero: assert property (rdSet && paddr > ADDR_CURRENT |=> prdata == 32'h0) else $error("unmapped");
  cover property ($rose(limiterActive));
  cover property (limiterActive && appliedCurrentLimit < $past(appliedCurrentLimit));
  cover property (rdSet && paddr > ADDR_CURRENT);
endmodule

// ### mol_current_source.sv
`timescale 1ns/1ns
module mol_current_source (
  input  wire logic        clk,
  input  wire logic [15:0] demand,
  input  wire logic [15:0] limit,
  output logic      [15:0] current
);
  // Settles in one cycle; a slower loop only stretches the time to the limit
  initial current = 16'h0;
  always @(posedge clk) current <= (demand > limit) ? limit : demand;
endmodule

// ### testbench.sv
`timescale 1ns/1ns
module testbench;
  import mol_pkg::*;
  logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, limiterActive;
  logic [11:0] paddr = 12'h0;
  logic [15:0] motorCurrent, appliedCurrentLimit, demand = 16'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h44, rated, pct, cl, pe, thr;
  int          err_count = 0, total_checks = 0;
  // 50 MHz clock
  always #10 clk = ~clk;
  mol_limiter #(.TICK_CYCLES_P(10)) uut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .motorCurrent, .appliedCurrentLimit, .limiterActive);
  mol_current_source drv (.clk, .demand, .limit(appliedCurrentLimit), .current(motorCurrent));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Peak in tenths of a percent of rated, capped by the ceiling
  function automatic logic [31:0] peak_of(logic [31:0] r, p, c);
    return (r * p / 1000 > c) ? c : r * p / 1000;
  endfunction
  task automatic chk(logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // Request held until pready is sampled high
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    {psel, penable} <= 2'b00;
  endtask
  task automatic wait_lim(logic [31:0] e);
    for (int k = 0; k < 400 && {16'h0, appliedCurrentLimit} !== e; k++) @(posedge clk);
  endtask
  task end_of_test;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    #400000;
    err_count++;
    end_of_test();
  end
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    apb(0, ADDR_PEAKPCT, 0);
    chk(rd, {16'h0, PEAKPCT_RST});
    apb(0, 12'h100, 0);
    chk(rd, 0);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      rated = 50 + xs() % 200;
      pct = 1500 + xs() % 2000;
      cl = (i == 1) ? rated + 10 : 4000;
      pe = peak_of(rated, pct, cl);
      apb(1, ADDR_MAXCUR, cl);
      apb(1, ADDR_RATED, rated);
      apb(1, ADDR_PEAKPCT, pct);
      apb(1, ADDR_PEAKDUR, (i == 2) ? 0 : 5);
      apb(0, ADDR_STATUS, 0);
      chk(rd, 0);
      apb(0, ADDR_LIMIT, 0);
      chk(rd, pe);
      apb(1, ADDR_CTRL, 1);
      apb(0, ADDR_STATUS, 0);
      chk(rd, 32'(i != 2));
      if (i != 2) begin
        thr = (pe * pe - rated * rated) * 5;
        apb(0, ADDR_THRESH, 0);
        chk(rd, thr);
        demand <= 16'hffff;
        wait_lim(rated);
        apb(0, ADDR_ACCUM, 0);
        chk({appliedCurrentLimit, 15'h0, rd >= thr}, {rated[15:0], 16'h1});
        demand <= 16'h0;
        wait_lim(pe);
        chk({16'h0, appliedCurrentLimit}, pe);
      end
      apb(1, ADDR_CTRL, 0);
      $display("config test %0d done", i);
    end
    end_of_test();
  end
endmodule
bind mol_limiter mol_limiter_properties #(.TICK_CYCLES_P(TICK_CYCLES_P)) chk_i (.clk, .rst_n, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .motorCurrent, .appliedCurrentLimit, .limiterActive);
